// ==== logic/rgbm_pkg.sv ====
package rgbm_pkg;
    // Register offsets
    localparam logic [6:0] REG_CTRL    = 7'h00;
    localparam logic [6:0] REG_CUR_R   = 7'h01;
    localparam logic [6:0] REG_CUR_G   = 7'h02;
    localparam logic [6:0] REG_CUR_B   = 7'h03;
    localparam logic [6:0] REG_BRIGHT  = 7'h05;
    localparam logic [6:0] REG_GAIN_R  = 7'h0A;
    localparam logic [6:0] REG_GAIN_G  = 7'h0B;
    localparam logic [6:0] REG_GAIN_B  = 7'h0C;
    localparam logic [6:0] REG_ADC_HI  = 7'h0D;
    localparam logic [6:0] REG_ADC_LO  = 7'h0E;
    localparam logic [6:0] REG_CAL_IDX = 7'h10;
    localparam logic [6:0] REG_CAL_LO  = 7'h11;
    localparam logic [6:0] REG_CAL_HI  = 7'h12;
    // Control field positions
    localparam int CTRL_LED_EN_BIT  = 0;
    localparam int CTRL_COMP_SEL_BIT = 1;
    localparam int CTRL_SA_INH_BIT  = 2;
    localparam int CTRL_AUTO_BIT    = 3;
    localparam int CTRL_SEQ_LSB     = 6;
    localparam int BRIGHT_LVL_W     = 3;
    // Reset values
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [7:0] BRIGHT_RST = 8'h07;
    localparam logic [7:0] GAIN_RST   = 8'h80;
    localparam logic [7:0] CUR_RST    = 8'h00;
    // Gain 0x80 is unity, so full scale is just under 2
    localparam int GAIN_SHIFT = 7;
    // Calibration memory layout
    localparam int         PWM_W        = 12;
    localparam int         CAL_AW       = 6;
    localparam int         CAL_POINTS   = 11;
    localparam int         CAL_CUR_BASE = 33;
    localparam logic [5:0] CAL_OFS_ADDR = 6'h24;
    localparam logic [5:0] CAL_SH_ADDR  = 6'h25;
    localparam logic [12:0] POS_MAX     = 13'h0A00;
    localparam logic [3:0] FADE_MAX     = 4'h8;
    // Timing
    localparam int CLK_FREQ_KHZ  = 10000;
    localparam int FADE_STEP_US  = 1000;
    localparam int FADE_STEP_CYC = FADE_STEP_US * CLK_FREQ_KHZ / 1000;

    typedef enum logic [1:0] {
        MODE_MANUAL = 2'b00,
        MODE_AUTO   = 2'b01,
        MODE_SEQ    = 2'b10
    } rgbm_mode_e;

    typedef enum logic [2:0] {
        ST_OFS  = 3'b000,
        ST_SH   = 3'b001,
        ST_POS  = 3'b010,
        ST_PA   = 3'b011,
        ST_PB   = 3'b100,
        ST_CUR  = 3'b101,
        ST_CALC = 3'b110
    } rgbm_state_e;
endpackage

// ==== logic/rgbm_cal_mem.sv ====
`timescale 1ns/1ps
module rgbm_cal_mem #(
    parameter int DW = 12,
    parameter int AW = 6
) (
    input  wire logic          core_clk,
    input  wire logic          clk_en,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);
    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge core_clk)
    begin
        if (clk_en && wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (clk_en)
        begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// ==== logic/rgbm_core.sv ====
`timescale 1ns/1ps
module rgbm_core
    import rgbm_pkg::*;
#(
    parameter int FADE_CYC = rgbm_pkg::FADE_STEP_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        clk_en,
    input  wire logic        spi_sck,
    input  wire logic        spi_ss_n,
    input  wire logic        spi_si,
    output logic             spi_so,
    input  wire logic        red_pwm_input,
    input  wire logic        green_pwm_input,
    input  wire logic        blue_pwm_input,
    input  wire logic        brightness_pwm_input,
    input  wire logic [11:0] sensor_one_input,
    input  wire logic [11:0] sensor_two_input,
    output logic      [2:0]  led_gate,
    output logic      [7:0]  red_current,
    output logic      [7:0]  green_current,
    output logic      [7:0]  blue_current
);
    import rgbm_pkg::*;

    logic [7:0]       ctrl_q;
    logic [7:0]       bright_q;
    logic [7:0]       gain_q [3];
    logic [7:0]       cur_q [3];
    logic [5:0]       cal_idx_q;
    logic [7:0]       cal_lo_q;
    logic             sck_prev_q;
    logic [4:0]       bit_cnt_q;
    logic [6:0]       sh_q;
    logic [6:0]       addr_q;
    logic [7:0]       rd_sh_q;
    logic             rd_flag_q;
    logic             sck_rise;
    logic             sck_fall;
    logic             wr_stb;
    logic [7:0]       wr_data;
    logic [6:0]       rd_addr;
    logic [7:0]       rd_val;
    logic [11:0]      adc_sel;
    rgbm_mode_e       mode;
    logic             standalone;
    logic [2:0]       ext_pwm;
    logic [PWM_W-1:0] pwm_cnt_q;
    logic [PWM_W-1:0] duty_q [3];
    logic [PWM_W-1:0] lut_pwm_q [3];
    logic [7:0]       lut_cur_q [3];
    logic [7:0]       cur_out_q [3];
    logic [2:0]       seq_left_q [3];
    logic [2:0]       ext_rise;

    assign ext_pwm = {blue_pwm_input, green_pwm_input, red_pwm_input};

    // Mode decode; auto bit clear always means manual
    always_comb
    begin
        if (!ctrl_q[CTRL_AUTO_BIT])
        begin
            mode = MODE_MANUAL;
        end
        else if (ctrl_q[CTRL_SEQ_LSB+:2] == 2'b00)
        begin
            mode = MODE_AUTO;
        end
        else
        begin
            mode = MODE_SEQ;
        end
    end

    // Registers at default with inhibit clear: brightness pin runs auto drive
    assign standalone = !ctrl_q[CTRL_SA_INH_BIT];
    assign adc_sel    = ctrl_q[CTRL_COMP_SEL_BIT] ? sensor_two_input
                                                  : sensor_one_input;

    // Serial port: first byte is {read, addr[6:0]}, second byte is data
    assign sck_rise = spi_sck && !sck_prev_q;
    assign sck_fall = !spi_sck && sck_prev_q;
    assign wr_stb   = !spi_ss_n && sck_rise && (bit_cnt_q == 5'd15) && !rd_flag_q;
    assign wr_data  = {sh_q, spi_si};
    assign rd_addr  = {sh_q[5:0], spi_si};

    always_comb
    begin
        unique case (rd_addr)
            REG_CTRL:    rd_val = ctrl_q;
            REG_CUR_R:   rd_val = cur_q[0];
            REG_CUR_G:   rd_val = cur_q[1];
            REG_CUR_B:   rd_val = cur_q[2];
            REG_BRIGHT:  rd_val = bright_q;
            REG_GAIN_R:  rd_val = gain_q[0];
            REG_GAIN_G:  rd_val = gain_q[1];
            REG_GAIN_B:  rd_val = gain_q[2];
            REG_ADC_HI:  rd_val = {4'h0, adc_sel[11:8]};
            REG_ADC_LO:  rd_val = adc_sel[7:0];
            REG_CAL_IDX: rd_val = {2'h0, cal_idx_q};
            REG_CAL_LO:  rd_val = cal_lo_q;
            default:     rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            sck_prev_q <= 1'b0;
            bit_cnt_q  <= 5'h00;
            sh_q       <= 7'h00;
            addr_q     <= 7'h00;
            rd_sh_q    <= 8'h00;
            rd_flag_q  <= 1'b0;
            spi_so     <= 1'b0;
        end
        else if (clk_en)
        begin
            sck_prev_q <= spi_sck;
            if (spi_ss_n)
            begin
                bit_cnt_q <= 5'h00;
                rd_sh_q   <= 8'h00;
                rd_flag_q <= 1'b0;
            end
            else if (sck_rise)
            begin
                sh_q      <= {sh_q[5:0], spi_si};
                bit_cnt_q <= bit_cnt_q + 5'h01;
                if (bit_cnt_q == 5'd7)
                begin
                    addr_q  <= rd_addr;
                    rd_sh_q   <= sh_q[6] ? rd_val : 8'h00;
                    rd_flag_q <= sh_q[6];
                end
            end
            else if (sck_fall && bit_cnt_q >= 5'd8)
            begin
                spi_so  <= rd_sh_q[7];
                rd_sh_q <= {rd_sh_q[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            ctrl_q    <= CTRL_RST;
            bright_q  <= BRIGHT_RST;
            gain_q    <= '{GAIN_RST, GAIN_RST, GAIN_RST};
            cur_q     <= '{CUR_RST, CUR_RST, CUR_RST};
            cal_idx_q <= 6'h00;
            cal_lo_q  <= 8'h00;
        end
        else if (clk_en && wr_stb)
        begin
            unique case (addr_q)
                REG_CTRL:    ctrl_q    <= wr_data;
                REG_CUR_R:   cur_q[0]  <= wr_data;
                REG_CUR_G:   cur_q[1]  <= wr_data;
                REG_CUR_B:   cur_q[2]  <= wr_data;
                REG_BRIGHT:  bright_q  <= wr_data;
                REG_GAIN_R:  gain_q[0] <= wr_data;
                REG_GAIN_G:  gain_q[1] <= wr_data;
                REG_GAIN_B:  gain_q[2] <= wr_data;
                REG_CAL_IDX: cal_idx_q <= wr_data[5:0];
                REG_CAL_LO:  cal_lo_q  <= wr_data;
                default:     ;
            endcase
        end
    end

    // Calibration lookup
    rgbm_state_e      st_q;
    logic [1:0]       col_q;
    logic [PWM_W-1:0] ofs_q;
    logic [PWM_W-1:0] sh_heat_q;
    logic [PWM_W-1:0] pa_q;
    logic [3:0]       pt_q;
    logic [7:0]       frac_q;
    logic [5:0]       mem_addr;
    logic [PWM_W-1:0] mem_data;
    logic [3:0]       pt_b;
    logic [12:0]      raw;
    logic [23:0]      heat;
    logic [12:0]      pos;
    logic signed [21:0] prod;
    logic signed [13:0] interp;
    logic [19:0]      gained;

    assign pt_b = (pt_q == 4'(CAL_POINTS - 1)) ? pt_q : pt_q + 4'h1;

    always_comb
    begin
        unique case (st_q)
            ST_OFS:  mem_addr = CAL_OFS_ADDR;
            ST_SH:   mem_addr = CAL_SH_ADDR;
            ST_PA:   mem_addr = 6'(col_q * CAL_POINTS + pos[11:8]);
            ST_PB:   mem_addr = 6'(col_q * CAL_POINTS + pt_b);
            ST_CUR:  mem_addr = 6'(CAL_CUR_BASE + col_q);
            default: mem_addr = CAL_OFS_ADDR;
        endcase
    end

    rgbm_cal_mem #(.DW(PWM_W), .AW(CAL_AW)) u_cal (
        .core_clk (core_clk),
        .clk_en   (clk_en),
        .wr_en    (wr_stb && addr_q == REG_CAL_HI),
        .wr_addr  (cal_idx_q),
        .wr_data  ({wr_data[3:0], cal_lo_q}),
        .rd_addr  (mem_addr),
        .rd_data  (mem_data)
    );

    always_comb
    begin
        raw    = {1'b0, adc_sel} - {1'b0, ofs_q};
        // No stored self-heating gives no offset, whatever the duty
        heat   = (sh_heat_q == '0) ? 24'h000000 : sh_heat_q * duty_q[0];
        pos    = (raw[12] ? 13'h0000 : raw) + {1'b0, heat[23:12]};
        if (pos > POS_MAX)
        begin
            pos = POS_MAX;
        end
        prod   = ($signed({1'b0, mem_data}) - $signed({1'b0, pa_q}))
                 * $signed({1'b0, frac_q});
        interp = $signed({2'b00, pa_q}) + 14'(prod >>> 8);
        gained = interp[11:0] * gain_q[col_q];
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            st_q      <= ST_OFS;
            col_q     <= 2'h0;
            ofs_q     <= '0;
            sh_heat_q <= '0;
            pa_q      <= '0;
            pt_q      <= 4'h0;
            frac_q    <= 8'h00;
            lut_pwm_q <= '{'0, '0, '0};
            lut_cur_q <= '{8'h00, 8'h00, 8'h00};
        end
        else if (clk_en)
        begin
            unique case (st_q)
                ST_OFS:  st_q <= ST_SH;
                ST_SH:
                begin
                    ofs_q <= mem_data;
                    st_q  <= ST_POS;
                end
                ST_POS:
                begin
                    sh_heat_q <= mem_data;
                    st_q      <= ST_PA;
                end
                ST_PA:
                begin
                    pt_q   <= pos[11:8];
                    frac_q <= pos[7:0];
                    st_q   <= ST_PB;
                end
                ST_PB:
                begin
                    pa_q <= mem_data;
                    st_q <= ST_CUR;
                end
                ST_CUR:
                begin
                    // Point b is on the memory output now
                    lut_pwm_q[col_q] <= (gained[19:GAIN_SHIFT] > 13'h0FFF) ? 12'hFFF
                                        : gained[GAIN_SHIFT+:PWM_W];
                    st_q             <= ST_CALC;
                end
                ST_CALC:
                begin
                    lut_cur_q[col_q] <= mem_data[7:0];
                    col_q <= (col_q == 2'h2) ? 2'h0 : col_q + 2'h1;
                    st_q  <= (col_q == 2'h2) ? ST_OFS : ST_PA;
                end
                default: st_q <= ST_OFS;
            endcase
        end
    end

    // Point a is addressed from the live position, point b from the stored one
    // Common fade level: 0 is off, 8 is full scale
    logic [3:0]  fade_lvl_q;
    logic [3:0]  fade_tgt;
    logic [31:0] fade_cnt_q;

    assign fade_tgt = ctrl_q[CTRL_LED_EN_BIT]
                      ? {1'b0, bright_q[BRIGHT_LVL_W-1:0]} + 4'h1 : 4'h0;

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            fade_lvl_q <= 4'h0;
            fade_cnt_q <= '0;
        end
        else if (clk_en)
        begin
            if (fade_cnt_q >= 32'(FADE_CYC - 1))
            begin
                fade_cnt_q <= '0;
                if (fade_lvl_q < fade_tgt)
                begin
                    fade_lvl_q <= fade_lvl_q + 4'h1;
                end
                else if (fade_lvl_q > fade_tgt)
                begin
                    fade_lvl_q <= fade_lvl_q - 4'h1;
                end
            end
            else
            begin
                fade_cnt_q <= fade_cnt_q + 32'h1;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            pwm_cnt_q <= '0;
        end
        else if (clk_en)
        begin
            pwm_cnt_q <= pwm_cnt_q + 1'b1;
        end
    end

    genvar c;
    generate
        for (c = 0; c < 3; c++)
        begin : g_col
            logic             ext_prev_q;
            logic [PWM_W-1:0] chan_cnt_q;
            logic             on;

            assign ext_rise[c] = ext_pwm[c] && !ext_prev_q;

            always_comb
            begin
                unique case (standalone ? MODE_AUTO : mode)
                    MODE_AUTO: on = pwm_cnt_q < duty_q[c];
                    MODE_SEQ:  on = seq_left_q[c] != 3'h0 && chan_cnt_q < duty_q[c];
                    default:   on = ext_pwm[c];
                endcase
            end

            always_ff @(posedge core_clk)
            begin
                if (reset)
                begin
                    // Idle pin level is high, so no false edge after reset
                    ext_prev_q    <= 1'b1;
                    chan_cnt_q    <= '0;
                    seq_left_q[c] <= 3'h0;
                end
                else if (clk_en)
                begin
                    ext_prev_q <= ext_pwm[c];
                    if (mode == MODE_SEQ && ext_rise[c])
                    begin
                        seq_left_q[c] <= {1'b0, ctrl_q[CTRL_SEQ_LSB+:2]} + 3'h1;
                        chan_cnt_q    <= '0;
                    end
                    else if (mode == MODE_SEQ && seq_left_q[c] != 3'h0)
                    begin
                        chan_cnt_q <= chan_cnt_q + 1'b1;
                        if (&chan_cnt_q)
                        begin
                            seq_left_q[c] <= seq_left_q[c] - 3'h1;
                        end
                    end
                    else
                    begin
                        seq_left_q[c] <= 3'h0;
                    end
                end
            end

            always_ff @(posedge core_clk)
            begin
                if (reset)
                begin
                    duty_q[c]    <= '0;
                    led_gate[c]  <= 1'b0;
                    cur_out_q[c] <= 8'h00;
                end
                else if (clk_en)
                begin
                    // Same shift on every colour keeps the colour ratio
                    duty_q[c] <= (fade_lvl_q == 4'h0) ? '0
                                 : lut_pwm_q[c] >> (FADE_MAX - fade_lvl_q);
                    led_gate[c] <= on && (!standalone || brightness_pwm_input);
                    cur_out_q[c] <= (mode == MODE_MANUAL && !standalone)
                                    ? cur_q[c] : lut_cur_q[c];
                end
            end
        end
    endgenerate

    assign red_current   = cur_out_q[0];
    assign green_current = cur_out_q[1];
    assign blue_current  = cur_out_q[2];

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    logic manual_eff;
    assign manual_eff = mode == MODE_MANUAL && !standalone;

    property p_mode_manual;
        !ctrl_q[CTRL_AUTO_BIT] |-> mode == MODE_MANUAL;
    endproperty
    a_mode_manual: assert property (p_mode_manual) else $error("auto bit clear not manual");

    property p_manual_gate;
        clk_en && manual_eff |=> led_gate == $past(ext_pwm);
    endproperty
    a_manual_gate: assert property (p_manual_gate) else $error("manual gate mismatch");

    property p_manual_cur;
        clk_en && manual_eff |=> red_current == $past(cur_q[0]);
    endproperty
    a_manual_cur: assert property (p_manual_cur) else $error("manual current mismatch");

    property p_auto_cur;
        clk_en && mode == MODE_AUTO |=> green_current == $past(lut_cur_q[1]);
    endproperty
    a_auto_cur: assert property (p_auto_cur) else $error("auto current mismatch");

    property p_overlap;
        clk_en && mode == MODE_AUTO && !standalone
            |=> led_gate[2] == ($past(pwm_cnt_q) < $past(duty_q[2]));
    endproperty
    a_overlap: assert property (p_overlap) else $error("overlap pwm mismatch");

    property p_seq_idle;
        clk_en && mode == MODE_SEQ && !standalone && seq_left_q[0] == 3'h0 |=> !led_gate[0];
    endproperty
    a_seq_idle: assert property (p_seq_idle) else $error("pulse outside sequence");

    property p_seq_start;
        clk_en && mode == MODE_SEQ && ext_rise[1]
            |=> seq_left_q[1] == {1'b0, $past(ctrl_q[7:6])} + 3'h1;
    endproperty
    a_seq_start: assert property (p_seq_start) else $error("sequence start count wrong");

    property p_fade_step;
        $changed(fade_lvl_q) |-> (fade_lvl_q == $past(fade_lvl_q) + 4'h1)
                              || (fade_lvl_q == $past(fade_lvl_q) - 4'h1);
    endproperty
    a_fade_step: assert property (p_fade_step) else $error("fade jumped");

    property p_bright_off;
        clk_en && fade_lvl_q == 4'h0 |=> duty_q[0] == '0 && duty_q[1] == '0;
    endproperty
    a_bright_off: assert property (p_bright_off) else $error("duty not zero when off");
endmodule

// ==== tb/rgbm_host.sv ====
`timescale 1ns/1ps
module rgbm_host (
    input  wire logic core_clk,
    output logic      spi_sck,
    output logic      spi_ss_n,
    output logic      spi_si,
    input  wire logic spi_so
);
    initial
    begin
        spi_sck  = 1'b0;
        spi_ss_n = 1'b1;
        spi_si   = 1'b0;
    end
    // One mode 0 frame, sck low five clocks and high four per bit; data taken before each fall
    task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
        for (int i = 15; i >= 0; i--)
        begin
            @(posedge core_clk);
            spi_ss_n <= 1'b0;
            spi_si   <= tx[i];
            repeat (4) @(posedge core_clk);
            spi_sck <= 1'b1;
            repeat (4) @(posedge core_clk);
            rx = {rx[6:0], spi_so};
            spi_sck <= 1'b0;
        end
        repeat (5) @(posedge core_clk);
        spi_ss_n <= 1'b1;
        // Released line shows no stale value
        spi_si <= ~spi_si;
        repeat (2) @(posedge core_clk);
    endtask
endmodule

// ==== tb/test_rgb_led_mode_compensation.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
    $display("[ERR] %s exp %0h got %0h", nm, (e), (g)); end end
module test_rgb_led_mode_compensation;
    import rgbm_pkg::*;
    logic        core_clk;
    logic        reset;
    logic        clk_en;
    logic        spi_sck;
    logic        spi_ss_n;
    logic        spi_si;
    logic        spi_so;
    logic [2:0]  pwm_in;
    logic        bright_in;
    logic [11:0] s1;
    logic [11:0] s2;
    logic [2:0]  led_gate;
    logic [7:0]  cur [3];
    logic [7:0]  ec [3];
    logic [7:0]  v;
    logic [7:0]  h;
    logic [2:0]  p;
    logic [2:0]  q;
    logic [11:0] w;
    int          n [3];
    int          mismatches;
    int          checks_done;
    logic [6:0]  ra [9] = '{REG_CTRL, REG_CUR_R, REG_CUR_G, REG_CUR_B, REG_BRIGHT,
                            REG_GAIN_R, REG_GAIN_G, REG_GAIN_B, 7'h04};
    logic [7:0]  rv [9] = '{CTRL_RST, CUR_RST, CUR_RST, CUR_RST, BRIGHT_RST,
                            GAIN_RST, GAIN_RST, GAIN_RST, 8'h00};

    rgbm_core #(.FADE_CYC(16)) rgbm_core_i (
        .core_clk(core_clk), .reset(reset), .clk_en(clk_en), .spi_sck(spi_sck),
        .spi_ss_n(spi_ss_n), .spi_si(spi_si), .spi_so(spi_so),
        .red_pwm_input(pwm_in[0]), .green_pwm_input(pwm_in[1]),
        .blue_pwm_input(pwm_in[2]), .brightness_pwm_input(bright_in),
        .sensor_one_input(s1), .sensor_two_input(s2), .led_gate(led_gate),
        .red_current(cur[0]), .green_current(cur[1]), .blue_current(cur[2]));
    rgbm_host rgbm_host_i (.core_clk(core_clk), .spi_sck(spi_sck), .spi_ss_n(spi_ss_n),
        .spi_si(spi_si), .spi_so(spi_so));

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] r;
        rgbm_host_i.xfer({1'b0, a, d}, r);
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] r);
        rgbm_host_i.xfer({1'b1, a, 8'h00}, r);
    endtask
    function automatic int duty(input int lut, input int gain, input int lvl);
        int g;
        g = (lut * gain) >> 7;
        if (g > 4095)
            g = 4095;
        return g >> (8 - lvl);
    endfunction
    // High cycles per colour over one full counter period
    task automatic measure(input int er, input int eg, input int eb);
        n = '{0, 0, 0};
        repeat (4096)
        begin
            @(negedge core_clk);
            for (int c = 0; c < 3; c++)
                n[c] += led_gate[c];
        end
        `CHK("red duty", er, n[0])
        `CHK("green duty", eg, n[1])
        `CHK("blue duty", eb, n[2])
    endtask
    task automatic results;
        if (mismatches == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial
    begin
        repeat (100000) @(posedge core_clk);
        mismatches++;
        results();
    end
    initial
    begin
        mismatches = 0;
        checks_done = 0;
        reset <= 1'b1;
        clk_en <= 1'b1;
        pwm_in <= 3'h7;
        bright_in <= 1'b0;
        s1 <= 12'h000;
        s2 <= 12'h000;
        void'($urandom(82));
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        foreach (ra[i])
        begin
            rd(ra[i], v);
            `CHK("reset value", rv[i], v)
        end
        h = 8'($urandom);
        wr(REG_GAIN_G, h);
        rd(REG_GAIN_G, v);
        `CHK("gain rw", h, v)
        wr(REG_CTRL, {2'($urandom_range(3, 1)), 6'h05});
        for (int c = 0; c < 3; c++)
        begin
            ec[c] = 8'($urandom);
            wr(REG_CUR_R + 7'(c), ec[c]);
        end
        wr(REG_BRIGHT, 8'h02);
        for (int c = 0; c < 3; c++)
            `CHK("manual current", ec[c], cur[c])
        p = 3'h7;
        repeat (64)
        begin
            @(posedge core_clk);
            q = p;
            p = 3'($urandom);
            pwm_in <= p;
            @(negedge core_clk);
            `CHK("manual gate", q, led_gate)
        end
        @(posedge core_clk);
        pwm_in <= 3'h7;
        for (int sel = 0; sel < 2; sel++)
        begin
            @(posedge core_clk);
            s1 <= 12'($urandom);
            s2 <= 12'($urandom);
            wr(REG_CTRL, 8'h05 | 8'(sel << 1));
            rd(REG_ADC_HI, h);
            rd(REG_ADC_LO, v);
            `CHK("sensor read", sel ? s2 : s1, {h[3:0], v})
        end
        for (int a = 0; a < 38; a++)
        begin
            w = a < 11 ? 12'hFFF : a < 22 ? 12'h000 : a < 33 ? 12'h800 : 12'h000;
            if (a >= 33 && a < 36)
            begin
                ec[a - 33] = 8'($urandom);
                w = {4'h0, ec[a - 33]};
            end
            wr(REG_CAL_IDX, 8'(a));
            wr(REG_CAL_LO, w[7:0]);
            wr(REG_CAL_HI, {4'h0, w[11:8]});
        end
        wr(REG_GAIN_B, 8'h40);
        wr(REG_BRIGHT, 8'h07);
        wr(REG_CTRL, 8'h0D);
        repeat (400) @(posedge core_clk);
        for (int c = 0; c < 3; c++)
            `CHK("auto current", ec[c], cur[c])
        measure(duty(4095, 128, 8), 0, duty(2048, 64, 8));
        wr(REG_BRIGHT, 8'h03);
        repeat (400) @(posedge core_clk);
        measure(duty(4095, 128, 4), 0, duty(2048, 64, 4));
        q = 3'($urandom_range(3, 1));
        wr(REG_CTRL, {q[1:0], 6'h0D});
        @(posedge core_clk);
        pwm_in <= 3'h4;
        @(posedge core_clk);
        pwm_in <= 3'h7;
        n = '{0, 0, 0};
        repeat (20480)
        begin
            @(negedge core_clk);
            for (int c = 0; c < 3; c++)
                n[c] += led_gate[c];
        end
        `CHK("seq red", (int'(q) + 1) * duty(4095, 128, 4), n[0])
        `CHK("seq blue", 0, n[2])
        results();
    end
endmodule
